// ---- hdl/sfr_map.svh ----
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SFR_OFS_CODE  8'h00
`define SFR_OFS_SYS2  8'h04
`define SFR_OFS_SCTL  8'h08
`define SFR_OFS_UCNT  8'h0C
`define SFR_OFS_STAT  8'h10
`define SFR_OFS_UDONE 8'h14

// ****************************************
// fields and reset values
// ****************************************
`define SFR_CODE_RST   8'h80
`define SFR_CODE_ERR   4
`define SFR_SYS2_FRE   0
`define SFR_SCTL_ARM   0
`define SFR_UCNT_RST   8'h30
`define SFR_BYTE_STRB  4'h1

// ****************************************
// link commands
// ****************************************
`define SFR_CMD_START  8'h55
`define SFR_CMD_ERDONE 8'h66
`define SFR_CMD_DATREQ 8'h77
`define SFR_CMD_OK     8'hAA

// ****************************************
// erase range, unit size, timing
// ****************************************
`define SFR_EB_FIRST   4'hA
`define SFR_EB_LAST    4'hC
`define SFR_UNIT_LAST  7'h7F
`define SFR_CLK_HZ     250000000
`define SFR_BAUD       38400

`endif

// ---- hdl/sfr_pkg.sv ----
package sfr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_LD_ER   = 4'h1,
    ST_ERASE   = 4'h2,
    ST_ER_WAIT = 4'h3,
    ST_TX_66   = 4'h4,
    ST_LD_PR   = 4'h5,
    ST_TX_77   = 4'h6,
    ST_RECV    = 4'h7,
    ST_PR_RD   = 4'h8,
    ST_PR_WR   = 4'h9,
    ST_PR_WAIT = 4'hA,
    ST_TX_AA   = 4'hB,
    ST_FAIL    = 4'hC
  } sfr_state_t;

endpackage : sfr_pkg

// ---- hdl/sfr_if.sv ----
interface sfr_uart_if;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       rx_valid;
  logic [7:0] rx_data;
  modport ctrl (output tx_valid, tx_data, input tx_ready, rx_valid, rx_data);
  modport uart (input tx_valid, tx_data, output tx_ready, rx_valid, rx_data);
endinterface : sfr_uart_if

interface sfr_buf_if #(
  parameter int AW = 7,
  parameter int W  = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [W-1:0]  wdata;
  logic [W-1:0]  rdata;
  modport ctrl (output we, waddr, raddr, wdata, input rdata);
  modport mem  (input we, waddr, raddr, wdata, output rdata);
endinterface : sfr_buf_if

// ---- hdl/sfr_buf.sv ----
module sfr_buf #(
  parameter int AW = 7,
  parameter int W  = 8
)(
  input wire logic pclk,
  sfr_buf_if.mem   b
);

  // ****************************************
  // one data unit, registered read
  // ****************************************
  logic [W-1:0] mem_q [2**AW];
  logic [W-1:0] rdata_q;

  always_ff @(posedge pclk)
  begin
    if (b.we)
      mem_q[b.waddr] <= b.wdata;
    rdata_q <= mem_q[b.raddr];
  end

  assign b.rdata = rdata_q;

endmodule : sfr_buf

// ---- hdl/sfr_uart.sv ----
module sfr_uart #(
  parameter int CLKS_PER_BIT = 6510
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rxd_pin,
  output wire logic txd,
  sfr_uart_if.uart  u
);

  localparam logic [15:0] BIT_CNT  = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_CNT = 16'(CLKS_PER_BIT / 2);

  logic [2:0]  rsync_q;
  logic        rx_lvl_q;
  logic        rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_valid_q;
  logic        tx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic        txd_q;

  // ****************************************
  // receiver: 8 data, no parity, 1 stop
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsync_q    <= 3'h7;
      rx_lvl_q   <= 1'b1;
      rx_busy_q  <= 1'b0;
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rsync_q    <= {rsync_q[1:0], rxd_pin};
      // glitch filter: line level moves only when stages two and three agree
      if (rsync_q[1] == rsync_q[2])
        rx_lvl_q <= rsync_q[2];
      rx_valid_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rx_lvl_q)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= HALF_CNT;
          rx_bit_q  <= 4'h0;
        end
      end
      else if (rx_cnt_q != 16'h0000)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= BIT_CNT;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0)
        begin
          if (rx_lvl_q)
            rx_busy_q <= 1'b0;
        end
        else if (rx_bit_q < 4'h9)
          rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]}; // [RULE1]
        else
        begin
          // a low stop bit is a framing error: the byte is dropped
          rx_busy_q  <= 1'b0;
          rx_valid_q <= rx_lvl_q; // [RULE1]
        end
      end
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
      txd_q     <= 1'b1;
    end
    else if (!tx_busy_q)
    begin
      if (u.tx_valid)
      begin
        tx_sh_q   <= {1'b1, u.tx_data, 1'b0}; // [RULE1]
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= 16'h0000;
        tx_bit_q  <= 4'h0;
      end
    end
    else if (tx_cnt_q != 16'h0000)
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    else if (tx_bit_q == 4'hA)
      tx_busy_q <= 1'b0;
    else
    begin
      txd_q    <= tx_sh_q[0];
      tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
      tx_cnt_q <= BIT_CNT;
      tx_bit_q <= tx_bit_q + 4'h1;
    end
  end

  assign u.tx_ready = ~tx_busy_q;
  assign u.rx_valid = rx_valid_q;
  assign u.rx_data  = rx_sh_q;
  assign txd        = txd_q;

endmodule : sfr_uart

// ---- hdl/sfr_ctrl.sv ----
// Contract
// [RULE1] link is 8N1 at 38400 baud
// [RULE2] host opens session with byte 0x55
// [RULE3] device sends 0x66 after erase completes
// [RULE4] device sends 0x77 to request next unit
// [RULE5] device sends 0xAA after all units programmed
// [RULE6] host times out silence as failure
// [RULE7] receive event only for start; irqs masked
// [RULE8] erase blocks ten to twelve before programming
// [RULE9] 128-byte units buffered, programmed at ascending addresses
// [RULE10] load erase routine, then programming routine
// [RULE11] control register needs access enable bit set
// [RULE12] access enable locks out timer unit registers
// [RULE13] interface registers are byte access only
// [RULE14] reset and standby entry restore initial values; standby does not clear unit_q (UDONE)
// [RULE15] error flag survives software standby and watch
// [RULE16] control/status register resets to 0x80
// [RULE17] bit7 reads one; bits 6,5,3..1 zero
// [RULE18] error flag set on failure, blocks operations
// [RULE19] error flag cleared by power-on or hardware standby
// [RULE20] after error, hold reset at least 100 us
// [RULE21] start, erase, report, request units, report success
`include "sfr_map.svh"
module sfr_ctrl #(
  parameter int                CLKS_PER_BIT = `SFR_CLK_HZ / `SFR_BAUD,
  parameter logic [23:0]       FLASH_BASE   = 24'h040000
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        uart_rxd,
  output wire logic        uart_txd,
  input  wire logic        hw_standby_pin,
  input  wire logic        sw_standby_pin,
  output logic             routine_load,
  output logic             routine_sel,
  input  wire logic        routine_ready,
  output logic             flash_erase,
  output logic      [3:0]  flash_erase_blk,
  output logic             flash_prog,
  output logic      [23:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  input  wire logic        flash_done,
  input  wire logic        flash_fail,
  output logic             irq_mask,
  output logic             start_irq,
  output logic             timer_unit_lock
);

  sfr_uart_if                 u_if ();
  sfr_buf_if #(.AW(7), .W(8)) b_if ();

  sfr_pkg::sfr_state_t state_q;
  sfr_pkg::sfr_state_t state_d;

  logic [2:0] hws_q;
  logic [2:0] sws_q;
  logic       hw_stby_q;
  logic       sw_stby_q;
  logic       err_flag_q;
  logic       fre_q;
  logic       arm_q;
  logic [7:0] ucnt_q;
  logic [7:0] unit_q;
  logic [7:0] unit_d;
  logic [6:0] byte_q;
  logic [6:0] byte_d;
  logic [3:0] blk_q;
  logic [3:0] blk_d;
  logic       tx_valid_q;
  logic [7:0] tx_data_q;
  logic       tx_go;
  logic [7:0] tx_byte;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;

  // ****************************************
  // standby pins and apb decode
  // ****************************************
  wire stby_clr  = hw_stby_q | sw_stby_q;
  wire setup     = psel & ~penable;
  wire wr        = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire hit_code  = paddr == `SFR_OFS_CODE;
  wire hit_sys2  = paddr == `SFR_OFS_SYS2;
  wire hit_sctl  = paddr == `SFR_OFS_SCTL;
  wire hit_ucnt  = paddr == `SFR_OFS_UCNT;
  wire hit_stat  = paddr == `SFR_OFS_STAT;
  wire hit_udone = paddr == `SFR_OFS_UDONE;
  wire unmapped  = ~(hit_code | hit_sys2 | hit_sctl | hit_ucnt |
                     hit_stat | hit_udone);
  wire code_lock = hit_code & ~fre_q; // [RULE11]
  wire bad_strb  = pwrite & (pstrb != `SFR_BYTE_STRB); // [RULE13]
  wire apb_err   = unmapped | code_lock | bad_strb;
  wire busy      = state_q != sfr_pkg::ST_IDLE;

  // fixed bits are not storage: a write cannot disturb them
  wire [7:0] code_val = `SFR_CODE_RST |
                        (8'(err_flag_q) << `SFR_CODE_ERR); // [RULE16] [RULE17]
  wire [7:0] stat_val = {busy, err_flag_q, 2'b00, state_q};
  wire [7:0] rd_byte  = hit_code  ? code_val :
                        hit_sys2  ? {7'h00, fre_q} :
                        hit_sctl  ? {7'h00, arm_q} :
                        hit_ucnt  ? ucnt_q :
                        hit_stat  ? stat_val :
                        hit_udone ? unit_q : 8'h00;

  wire we_sys2 = wr & hit_sys2;
  wire we_sctl = wr & hit_sctl;
  wire we_ucnt = wr & hit_ucnt;

  // ****************************************
  // session events
  // ****************************************
  wire rx_start = u_if.rx_valid & (u_if.rx_data == `SFR_CMD_START) &
                  arm_q & ~err_flag_q & ~busy; // [RULE2] [RULE7] [RULE18]
  wire flash_wait = (state_q == sfr_pkg::ST_ER_WAIT) |
                    (state_q == sfr_pkg::ST_PR_WAIT);
  wire unit_end   = byte_q == `SFR_UNIT_LAST;
  wire tx_free    = u_if.tx_ready & ~tx_valid_q;
  wire enter_ld   = (state_d == sfr_pkg::ST_LD_ER ||
                     state_d == sfr_pkg::ST_LD_PR) && state_d != state_q;

  assign u_if.tx_valid = tx_valid_q;
  assign u_if.tx_data  = tx_data_q;
  assign b_if.we       = (state_q == sfr_pkg::ST_RECV) & u_if.rx_valid;
  assign b_if.waddr    = byte_q;
  assign b_if.wdata    = u_if.rx_data;
  assign b_if.raddr    = byte_q;

  sfr_uart #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_uart (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd_pin (uart_rxd),
    .txd     (uart_txd),
    .u       (u_if.uart)
  );

  sfr_buf #(
    .AW (7),
    .W  (8)
  ) u_buf (
    .pclk (pclk),
    .b    (b_if.mem)
  );

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    unit_d  = unit_q;
    byte_d  = byte_q;
    blk_d   = blk_q;
    tx_go   = 1'b0;
    tx_byte = 8'h00;
    unique case (state_q)
      sfr_pkg::ST_IDLE:
        if (rx_start)
        begin
          state_d = sfr_pkg::ST_LD_ER; // [RULE21]
          blk_d   = `SFR_EB_FIRST; // [RULE8]
          unit_d  = 8'h00;
        end
      sfr_pkg::ST_LD_ER:
        if (routine_ready)
          state_d = sfr_pkg::ST_ERASE; // [RULE10]
      sfr_pkg::ST_ERASE:
        state_d = sfr_pkg::ST_ER_WAIT;
      sfr_pkg::ST_ER_WAIT:
        if (flash_fail)
          state_d = sfr_pkg::ST_FAIL;
        else if (flash_done)
        begin
          if (blk_q == `SFR_EB_LAST)
            state_d = sfr_pkg::ST_TX_66; // [RULE8]
          else
          begin
            blk_d   = blk_q + 4'h1;
            state_d = sfr_pkg::ST_ERASE;
          end
        end
      sfr_pkg::ST_TX_66:
        if (tx_free)
        begin
          tx_go   = 1'b1;
          tx_byte = `SFR_CMD_ERDONE; // [RULE3]
          state_d = sfr_pkg::ST_LD_PR;
        end
      sfr_pkg::ST_LD_PR:
        if (routine_ready)
        begin
          byte_d  = 7'h00;
          state_d = (ucnt_q == 8'h00) ? sfr_pkg::ST_TX_AA
                                      : sfr_pkg::ST_TX_77; // [RULE10]
        end
      sfr_pkg::ST_TX_77:
        if (tx_free)
        begin
          tx_go   = 1'b1;
          tx_byte = `SFR_CMD_DATREQ; // [RULE4]
          state_d = sfr_pkg::ST_RECV;
        end
      sfr_pkg::ST_RECV:
        if (u_if.rx_valid)
        begin
          byte_d = byte_q + 7'h01; // [RULE9]
          if (unit_end)
            state_d = sfr_pkg::ST_PR_RD;
        end
      sfr_pkg::ST_PR_RD:
        state_d = sfr_pkg::ST_PR_WR;
      sfr_pkg::ST_PR_WR:
        state_d = sfr_pkg::ST_PR_WAIT;
      sfr_pkg::ST_PR_WAIT:
        if (flash_fail)
          state_d = sfr_pkg::ST_FAIL;
        else if (flash_done)
        begin
          byte_d = byte_q + 7'h01;
          if (!unit_end)
            state_d = sfr_pkg::ST_PR_RD;
          else
          begin
            unit_d  = unit_q + 8'h01; // [RULE9]
            state_d = (unit_q + 8'h01 == ucnt_q) ? sfr_pkg::ST_TX_AA
                                                 : sfr_pkg::ST_TX_77;
          end
        end
      sfr_pkg::ST_TX_AA:
        if (tx_free)
        begin
          tx_go   = 1'b1;
          tx_byte = `SFR_CMD_OK; // [RULE5]
          state_d = sfr_pkg::ST_IDLE;
        end
      sfr_pkg::ST_FAIL:
        // no error byte exists; the host sees only silence
        state_d = sfr_pkg::ST_IDLE;
      default:
        state_d = sfr_pkg::ST_IDLE;
    endcase
    if (stby_clr)
      state_d = sfr_pkg::ST_IDLE; // [RULE14]
  end

  // ****************************************
  // standby synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hws_q     <= 3'h0;
      sws_q     <= 3'h0;
      hw_stby_q <= 1'b0;
      sw_stby_q <= 1'b0;
    end
    else
    begin
      hws_q <= {hws_q[1:0], hw_standby_pin};
      sws_q <= {sws_q[1:0], sw_standby_pin};
      if (hws_q[1] == hws_q[2])
        hw_stby_q <= hws_q[2];
      if (sws_q[1] == sws_q[2])
        sw_stby_q <= sws_q[2];
    end
  end

  // ****************************************
  // apb slave: zero wait states
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & apb_err;
      prdata_q  <= (setup & ~pwrite & ~apb_err) ? {24'h000000, rd_byte}
                                                : 32'h0000_0000;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fre_q  <= 1'b0;
      arm_q  <= 1'b0;
      ucnt_q <= `SFR_UCNT_RST;
    end
    else if (stby_clr)
    begin
      fre_q  <= 1'b0; // [RULE14]
      arm_q  <= 1'b0;
      ucnt_q <= `SFR_UCNT_RST;
    end
    else
    begin
      if (we_sys2)
        fre_q <= pwdata[`SFR_SYS2_FRE];
      if (we_sctl)
        arm_q <= pwdata[`SFR_SCTL_ARM];
      if (we_ucnt)
        ucnt_q <= pwdata[7:0];
    end
  end

  // software standby leaves this flag alone; a failure beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_flag_q <= 1'b0; // [RULE19]
    else if (flash_wait & flash_fail)
      err_flag_q <= 1'b1; // [RULE18]
    else if (hw_stby_q)
      err_flag_q <= 1'b0; // [RULE19] [RULE15]
  end

  // ****************************************
  // sequencer state and outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= sfr_pkg::ST_IDLE;
      unit_q     <= 8'h00;
      byte_q     <= 7'h00;
      blk_q      <= 4'h0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end
    else
    begin
      state_q    <= state_d;
      unit_q     <= unit_d;
      byte_q     <= stby_clr ? 7'h00 : byte_d;
      blk_q      <= blk_d;
      tx_valid_q <= tx_go;
      if (tx_go)
        tx_data_q <= tx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      routine_load    <= 1'b0;
      routine_sel     <= 1'b0;
      flash_erase     <= 1'b0;
      flash_erase_blk <= 4'h0;
      flash_prog      <= 1'b0;
      flash_addr      <= 24'h000000;
      flash_wdata     <= 8'h00;
      irq_mask        <= 1'b0;
      start_irq       <= 1'b0;
    end
    else
    begin
      routine_load <= enter_ld; // [RULE10]
      if (enter_ld)
        routine_sel <= state_d == sfr_pkg::ST_LD_PR;
      flash_erase <= state_q == sfr_pkg::ST_ERASE; // [RULE8]
      if (state_q == sfr_pkg::ST_ERASE)
        flash_erase_blk <= blk_q;
      flash_prog <= state_q == sfr_pkg::ST_PR_WR; // [RULE9]
      if (state_q == sfr_pkg::ST_PR_WR)
      begin
        flash_addr  <= FLASH_BASE + {9'h000, unit_q, byte_q};
        flash_wdata <= b_if.rdata;
      end
      irq_mask  <= state_d != sfr_pkg::ST_IDLE; // [RULE7]
      start_irq <= rx_start; // [RULE7]
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign timer_unit_lock = fre_q; // [RULE12]

endmodule : sfr_ctrl

// ---- tb/sfr_ctrl_properties.sv ----
module sfr_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        routine_load,
  input wire logic        routine_sel,
  input wire logic        flash_erase,
  input wire logic [3:0]  flash_erase_blk,
  input wire logic        flash_prog,
  input wire logic        irq_mask,
  input wire logic        start_irq,
  input wire logic        timer_unit_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic setup_w = psel && !penable;

  a_gate_code: assert property (
    setup_w && paddr == 8'h00 && !timer_unit_lock |=> pready && pslverr)
    else $error("status access not refused while disabled");
  a_byte_only: assert property (
    setup_w && pwrite && pstrb != 4'h1 |=> pready && pslverr)
    else $error("wide write not refused");
  a_code_value: assert property (
    psel && penable && pready && !pslverr && !pwrite && paddr == 8'h00
    |-> (prdata & ~32'h10) == 32'h80)
    else $error("status constant bits wrong");
  a_start_load: assert property (
    start_irq |-> routine_load && !routine_sel)
    else $error("start did not load the erase routine");
  a_mask_ops: assert property (
    flash_erase || flash_prog |-> irq_mask)
    else $error("flash operation with interrupts open");
  a_erase_blk: assert property (
    flash_erase |-> flash_erase_blk inside {[4'hA:4'hC]})
    else $error("erase outside blocks ten to twelve");
  a_prog_sel: assert property (
    flash_prog |-> routine_sel && !flash_erase)
    else $error("program without programming routine");
  a_lock_follow: assert property (
    setup_w && pwrite && paddr == 8'h04 && pstrb == 4'h1
    |=> ##1 timer_unit_lock == $past(pwdata[0], 2))
    else $error("timer lock does not follow enable bit");
endmodule : sfr_ctrl_chk

bind sfr_ctrl sfr_ctrl_chk u_chk (.*);

// ---- tb/sfr_host_model.sv ----
module sfr_host_model #(
  parameter int CLKS_PER_BIT = 8
)(
  input  wire logic pclk,
  output logic      to_dev,
  input  wire logic from_dev
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  initial to_dev = 1'b1;

  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      to_dev <= f[i];
      repeat (CLKS_PER_BIT) @(posedge pclk);
    end
  endtask : send

  task open_session();
    send(8'h55);
  endtask : open_session

  // silence past the limit is how a failed session shows
  task get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    ok = rx_q.size() != 0;
    b = ok ? rx_q.pop_front() : 8'h00;
  endtask : get

  always
  begin : rx
    logic [7:0] b;
    @(negedge from_dev);
    repeat (CLKS_PER_BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (CLKS_PER_BIT) @(posedge pclk);
      b[i] = from_dev;
    end
    repeat (CLKS_PER_BIT) @(posedge pclk);
    if (from_dev === 1'b1)
      rx_q.push_back(b);
  end
endmodule : sfr_host_model

// ---- tb/sfr_ctrl_tb.sv ----
module sfr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          CPB  = 8;
  localparam logic [23:0] BASE = 24'h012300;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        hw_standby_pin = 0, sw_standby_pin = 0, fail_mode = 0;
  logic        routine_ready = 0, flash_done = 0, flash_fail = 0;
  logic [31:0] prdata;
  logic [23:0] flash_addr;
  logic [7:0]  flash_wdata;
  logic [3:0]  flash_erase_blk;
  logic        pready, pslverr, uart_rxd, uart_txd, routine_load;
  logic        routine_sel, flash_erase, flash_prog, irq_mask, start_irq;
  logic        timer_unit_lock;
  int          err_total = 0, checks = 0;
  logic [31:0] exp_blk[$], exp_prog[$];

  always #2 pclk = ~pclk;

  sfr_ctrl #(.CLKS_PER_BIT(CPB), .FLASH_BASE(BASE)) dut (.*);
  sfr_host_model #(.CLKS_PER_BIT(CPB)) host (
    .pclk(pclk), .to_dev(uart_rxd), .from_dev(uart_txd));

  // ****
  // flash and routine loader stand-in, answers one cycle late
  // ****
  always @(posedge pclk)
  begin
    routine_ready <= routine_load;
    flash_done <= (flash_erase | flash_prog) & ~fail_mode;
    flash_fail <= (flash_erase | flash_prog) & fail_mode;
    if (flash_erase === 1'b1)
      chk_flash({28'h0, flash_erase_blk}, exp_blk.pop_front());
    if (flash_prog === 1'b1)
      chk_flash({flash_addr, flash_wdata}, exp_prog.pop_front());
  end

  task chk_reg(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_reg

  task chk_link(input logic [7:0] g, e);
    chk_reg({24'h0, g}, {24'h0, e});
  endtask : chk_link

  task chk_flash(input logic [31:0] g, e);
    chk_reg(g, e);
  endtask : chk_flash

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [31:0] ed, input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (!w)
      chk_reg(prdata, ed);
    chk_reg({30'h0, pready, pslverr}, {30'h0, 1'b1, ee});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // 8'h00 stands for silence: the device never sends it
  task expect_byte(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    host.get(b, ok);
    chk_link(ok ? b : 8'h00, e);
  endtask : expect_byte

  task session(input int units);
    logic [7:0] b;
    for (int i = 10; i <= 12; i++)
      exp_blk.push_back(i);
    host.open_session();
    expect_byte(8'h66);
    chk_reg(exp_blk.size(), 0);
    for (int u = 0; u < units; u++)
    begin
      expect_byte(8'h77);
      for (int k = 0; k < 128; k++)
      begin
        b = 8'($urandom);
        exp_prog.push_back({BASE + 24'(u * 128 + k), b});
        host.send(b);
      end
    end
    expect_byte(8'hAA);
    chk_reg(exp_prog.size(), 0);
    $display("session of %0d units done", units);
  endtask : session

  task standby(input logic hw);
    hw_standby_pin <= hw;
    sw_standby_pin <= !hw;
    repeat (10) @(posedge pclk);
    hw_standby_pin <= 1'b0;
    sw_standby_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1, 8'h04, 32'h1, 4'h1, 0, 0);
  endtask : standby

  task stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (90000) @(posedge pclk);
    err_total++;
    stop_test();
  end

  initial
  begin
    void'($urandom(97));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0, 4'h0, 0, 1);
    apb(0, 8'h0C, 0, 4'h0, 32'h30, 0);
    apb(0, 8'h20, 0, 4'h0, 0, 1);
    apb(1, 8'h04, 32'h1, 4'h3, 0, 1);
    apb(1, 8'h04, 32'h1, 4'h1, 0, 0);
    @(posedge pclk);
    chk_reg({31'h0, timer_unit_lock}, 32'h1);
    apb(1, 8'h00, 32'h80, 4'h1, 0, 0);
    apb(0, 8'h00, 0, 4'h0, 32'h80, 0);
    $display("register test done");
    apb(1, 8'h08, 32'h1, 4'h1, 0, 0);
    apb(1, 8'h0C, 32'h2, 4'h1, 0, 0);
    session(2);
    apb(0, 8'h14, 0, 4'h0, 32'h2, 0);
    apb(1, 8'h0C, 32'h0, 4'h1, 0, 0);
    session(0);
    fail_mode <= 1'b1;
    exp_blk.push_back(10);
    host.open_session();
    expect_byte(8'h00);
    apb(0, 8'h00, 0, 4'h0, 32'h90, 0);
    fail_mode <= 1'b0;
    host.open_session();
    expect_byte(8'h00);
    $display("error test done");
    standby(1'b0);
    apb(0, 8'h0C, 0, 4'h0, 32'h30, 0);
    apb(0, 8'h00, 0, 4'h0, 32'h90, 0);
    standby(1'b1);
    apb(0, 8'h00, 0, 4'h0, 32'h80, 0);
    $display("standby test done");
    apb(1, 8'h08, 32'h1, 4'h1, 0, 0);
    fail_mode <= 1'b1;
    exp_blk.push_back(10);
    host.open_session();
    expect_byte(8'h00);
    fail_mode <= 1'b0;
    presetn <= 1'b0;
    repeat (25000) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0, 4'h0, 0, 1);
    apb(1, 8'h04, 32'h1, 4'h1, 0, 0);
    apb(0, 8'h00, 0, 4'h0, 32'h80, 0);
    $display("reset test done");
    stop_test();
  end
endmodule : sfr_ctrl_tb
